/* src/lsp_defs.svh */
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSP_OFF_CLK 8'h31
`define LSP_OFF_D0 8'h32
`define LSP_OFF_D1 8'h33
`define LSP_OFF_D2 8'h34
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define LSP_SWING_HI 7
`define LSP_SWING_LO 5
`define LSP_EMPH_HI 4
`define LSP_EMPH_LO 3
`define LSP_RSVD_HI 2
`define LSP_RSVD_LO 0
`define LSP_RST_VAL 8'h00
`define LSP_GCTL_ORDER_BIT 7
`define LSP_GCTL_INDIV_BIT 6
`define LSP_GCTL_PKT_BIT 5
`define LSP_NUM_LANES 4
`endif

/* src/lsp_pkg.sv */
package lsp_pkg;
  typedef enum logic [2:0] {
    LSP_SW_NOMINAL = 3'h0,
    LSP_SW_UP7 = 3'h1,
    LSP_SW_UP14 = 3'h2,
    LSP_SW_UP21 = 3'h3,
    LSP_SW_DN30 = 3'h4,
    LSP_SW_DN21 = 3'h5,
    LSP_SW_DN14 = 3'h6,
    LSP_SW_DN7 = 3'h7
  } lsp_swing_type;
  typedef enum logic [1:0] {
    LSP_EM_NONE = 2'h0,
    LSP_EM_3P5DB = 2'h1,
    LSP_EM_6DB = 2'h2,
    LSP_EM_RSVD = 2'h3
  } lsp_emph_type;
endpackage : lsp_pkg

/* src/lsp_lane_regs.sv */
`timescale 1ns/1ps
`include "lsp_defs.svh"
// Function
// - four drive registers sit at 0x31 (clock lane), 0x32, 0x33 and 0x34 (data lanes 0 to 2).
// - bits 7:5 hold the swing code and bits 4:3 the pre-emphasis code, read/write, reset to zero.
// - swing code 000 is nominal and 001, 010, 011 raise the swing by 7, 14 and 21 percent.
// - swing codes 100, 101, 110, 111 lower the swing by 30, 21, 14 and 7 percent.
// - pre-emphasis 00 is none and the reset value, 01 gives 3.5 dB and 10 gives 6 dB.
// - per-lane fields act only while individual lane control is one, else the global setting applies.
// - per-lane values count as packet link mode settings, valid only while that mode bit is one.
// - in HDMI mode (lane order bit zero) writes to the clock lane pre-emphasis field are dropped.
// - in HDMI mode the clock lane gets no pre-emphasis whatever code is held.
// - bits 2:0 are reserved read/write bits, reset to zero, with no effect on the lanes.
module lsp_lane_regs
  import lsp_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic cfg_wr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_hit_out,
  input wire logic [7:0] global_lane_control_reg_in,
  input wire logic [2:0] glb_swing_in,
  input wire logic [1:0] glb_emph_in,
  output lsp_swing_type lane_swing_out [`LSP_NUM_LANES],
  output lsp_emph_type lane_emph_out [`LSP_NUM_LANES]
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [7:0] drive_q [`LSP_NUM_LANES];
  logic [7:0] drive_d [`LSP_NUM_LANES];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  lsp_swing_type swing_q [`LSP_NUM_LANES];
  lsp_swing_type swing_d [`LSP_NUM_LANES];
  lsp_emph_type emph_q [`LSP_NUM_LANES];
  lsp_emph_type emph_d [`LSP_NUM_LANES];
  logic [7:0] lane_off [`LSP_NUM_LANES];
  logic hdmi_mode;
  logic per_lane_on;

  assign lane_off[0] = `LSP_OFF_CLK;
  assign lane_off[1] = `LSP_OFF_D0;
  assign lane_off[2] = `LSP_OFF_D1;
  assign lane_off[3] = `LSP_OFF_D2;
  assign hdmi_mode = ~global_lane_control_reg_in[`LSP_GCTL_ORDER_BIT];
  // both enables must be set; packet link mode gates validity of the bank
  assign per_lane_on = global_lane_control_reg_in[`LSP_GCTL_INDIV_BIT] &
                       global_lane_control_reg_in[`LSP_GCTL_PKT_BIT];

  // ----------------------------------------
  // write path and read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    cfg_hit_out = 1'b0;
    for (int i = 0; i < `LSP_NUM_LANES; i++) begin
      drive_d[i] = drive_q[i];
      if (cfg_addr_in == lane_off[i]) begin
        cfg_hit_out = 1'b1;
        rdata_d = drive_q[i];
        if (cfg_wr_in) begin
          drive_d[i] = cfg_wdata_in;
          // clock lane emphasis field keeps its old value in HDMI mode
          if (i == 0 && hdmi_mode) begin
            drive_d[i][`LSP_EMPH_HI:`LSP_EMPH_LO] = drive_q[i][`LSP_EMPH_HI:`LSP_EMPH_LO];
          end
        end
      end
    end
  end

  // ----------------------------------------
  // effective drive per lane
  // ----------------------------------------
  // reserved bits 2:0 never reach the lane outputs
  always_comb begin
    for (int i = 0; i < `LSP_NUM_LANES; i++) begin
      if (per_lane_on) begin
        swing_d[i] = lsp_swing_type'(drive_q[i][`LSP_SWING_HI:`LSP_SWING_LO]);
        emph_d[i] = lsp_emph_type'(drive_q[i][`LSP_EMPH_HI:`LSP_EMPH_LO]);
      end else begin
        swing_d[i] = lsp_swing_type'(glb_swing_in);
        emph_d[i] = lsp_emph_type'(glb_emph_in);
      end
      // reserved code is not trusted from software; treated as no emphasis
      if (emph_d[i] == LSP_EM_RSVD) begin
        emph_d[i] = LSP_EM_NONE;
      end
      if (i == 0 && hdmi_mode) begin
        emph_d[i] = LSP_EM_NONE;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_q <= 8'h00;
      for (int i = 0; i < `LSP_NUM_LANES; i++) begin
        drive_q[i] <= `LSP_RST_VAL;
        swing_q[i] <= LSP_SW_NOMINAL;
        emph_q[i] <= LSP_EM_NONE;
      end
    end else if (clk_en_in) begin
      rdata_q <= rdata_d;
      for (int i = 0; i < `LSP_NUM_LANES; i++) begin
        drive_q[i] <= drive_d[i];
        swing_q[i] <= swing_d[i];
        emph_q[i] <= emph_d[i];
      end
    end
  end

  assign cfg_rdata_out = rdata_q;
  assign lane_swing_out = swing_q;
  assign lane_emph_out = emph_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_wr_lane(int k);
    clk_en_in && cfg_wr_in && cfg_addr_in == lane_off[k];
  endsequence

  // clock lane write, split by mode: the emphasis field is only writable outside hdmi mode
  sequence s_clk_wr_hdmi;
    clk_en_in && cfg_wr_in && cfg_addr_in == lane_off[0] && hdmi_mode;
  endsequence

  sequence s_clk_wr_pkt;
    clk_en_in && cfg_wr_in && cfg_addr_in == lane_off[0] && !hdmi_mode;
  endsequence

  sequence s_wr_unmapped;
    clk_en_in && cfg_wr_in && !cfg_hit_out;
  endsequence

  chk_wr_d0_back: assert property (s_wr_lane(1) |=> drive_q[1] == $past(cfg_wdata_in))
    else $error("data lane 0 write not stored");
  chk_wr_d2_back: assert property (s_wr_lane(3) |=> drive_q[3] == $past(cfg_wdata_in))
    else $error("data lane 2 write not stored");
  chk_clk_emph_hold: assert property (s_clk_wr_hdmi |=> drive_q[0][4:3] == $past(drive_q[0][4:3]))
    else $error("clock emphasis changed in hdmi mode");
  chk_clk_swing_hdmi: assert property (s_wr_lane(0) |=> drive_q[0][7:5] == $past(cfg_wdata_in[7:5]))
    else $error("clock lane swing write lost");
  chk_clk_no_emph: assert property (clk_en_in && hdmi_mode |=> emph_q[0] == LSP_EM_NONE)
    else $error("clock lane emphasis in hdmi mode");
  chk_global_follow: assert property (clk_en_in && !per_lane_on |=> swing_q[2] == $past(glb_swing_in))
    else $error("lane did not follow global swing");
  chk_pkt_gate: assert property (clk_en_in && per_lane_on |=> swing_q[1] == $past(drive_q[1][7:5]))
    else $error("per-lane swing not applied");
  chk_emph_map: assert property (clk_en_in && per_lane_on && drive_q[2][4:3] == 2'h1 |=> emph_q[2] == LSP_EM_3P5DB)
    else $error("emphasis code mismatch");
  chk_swing_dn: assert property (clk_en_in && per_lane_on && drive_q[3][7:5] == 3'h4 |=> swing_q[3] == LSP_SW_DN30)
    else $error("swing decrease code mismatch");
  chk_swing_up: assert property (clk_en_in && per_lane_on && drive_q[3][7:5] == 3'h3 |=> swing_q[3] == LSP_SW_UP21)
    else $error("swing increase code mismatch");
  chk_rsvd_read: assert property (clk_en_in && cfg_addr_in == lane_off[2] |=> cfg_rdata_out[2:0] == $past(drive_q[2][2:0]))
    else $error("reserved bits not read back");
  chk_no_rsvd_emph: assert property (emph_q[1] != LSP_EM_RSVD)
    else $error("reserved emphasis applied");
  chk_no_rsvd_emph3: assert property (emph_q[3] != LSP_EM_RSVD)
    else $error("reserved emphasis applied on lane 3");

  // ----------------------------------------
  // more write and decode checks
  // ----------------------------------------
  chk_wr_d1_back: assert property (s_wr_lane(2) |=> drive_q[2] == $past(cfg_wdata_in))
    else $error("data lane 1 write not stored");
  chk_clk_wr_pkt: assert property (s_clk_wr_pkt |=> drive_q[0] == $past(cfg_wdata_in))
    else $error("clock lane write lost outside hdmi mode");
  chk_unmapped_wr: assert property (s_wr_unmapped |=> drive_q[0] == $past(drive_q[0]) && drive_q[1] == $past(drive_q[1])
                                    && drive_q[2] == $past(drive_q[2]) && drive_q[3] == $past(drive_q[3]))
    else $error("unmapped write changed a lane register");
  chk_unmapped_rd: assert property (clk_en_in && !cfg_hit_out |=> cfg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_hit_decode: assert property (cfg_hit_out == (cfg_addr_in >= 8'h31 && cfg_addr_in <= 8'h34))
    else $error("address decode wrong");
  chk_rsvd_read0: assert property (clk_en_in && cfg_addr_in == lane_off[0] |=> cfg_rdata_out[2:0] == $past(drive_q[0][2:0]))
    else $error("clock lane reserved bits not read back");

  // ----------------------------------------
  // code mapping checks
  // ----------------------------------------
  chk_emph_6db: assert property (clk_en_in && per_lane_on && drive_q[1][4:3] == 2'h2 |=> emph_q[1] == LSP_EM_6DB)
    else $error("6 dB emphasis code mismatch");
  chk_emph_none: assert property (clk_en_in && per_lane_on && drive_q[3][4:3] == 2'h0 |=> emph_q[3] == LSP_EM_NONE)
    else $error("no emphasis code mismatch");
  chk_swing_nom: assert property (clk_en_in && per_lane_on && drive_q[0][7:5] == 3'h0 |=> swing_q[0] == LSP_SW_NOMINAL)
    else $error("nominal swing code mismatch");
  chk_swing_up7: assert property (clk_en_in && per_lane_on && drive_q[1][7:5] == 3'h1 |=> swing_q[1] == LSP_SW_UP7)
    else $error("swing up 7 code mismatch");
  chk_swing_dn7: assert property (clk_en_in && per_lane_on && drive_q[2][7:5] == 3'h7 |=> swing_q[2] == LSP_SW_DN7)
    else $error("swing down 7 code mismatch");
  chk_global_emph: assert property (clk_en_in && !per_lane_on && glb_emph_in == 2'h1 |=> emph_q[3] == LSP_EM_3P5DB)
    else $error("lane did not follow global emphasis");

  // ----------------------------------------
  // clock enable freeze
  // ----------------------------------------
  // a stalled enable must not let a write slip through, or software would see a value it never confirmed
  chk_en_hold_reg: assert property (!clk_en_in |=> $stable(drive_q[1]) && $stable(drive_q[0]))
    else $error("register changed while enable low");
  chk_en_hold_rd: assert property (!clk_en_in |=> $stable(cfg_rdata_out))
    else $error("read data changed while enable low");
  chk_en_hold_lane: assert property (!clk_en_in |=> $stable(swing_q[1]) && $stable(emph_q[1]))
    else $error("lane drive changed while enable low");
endmodule : lsp_lane_regs

/* tb/lsp_lane_regs_tb.sv */
`timescale 1ns/1ps
`include "lsp_defs.svh"
module lane_swing_preemphasis_regs_tb_top
  import lsp_pkg::*;
;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic cfg_wr_in = 1'b0;
  logic [7:0] cfg_addr_in = 8'h00, cfg_wdata_in = 8'h00, gctl = 8'h00, cfg_rdata_out;
  logic [2:0] glb_swing_in = 3'h0;
  logic [1:0] glb_emph_in = 2'h0;
  logic cfg_hit_out;
  lsp_swing_type lane_swing_out [`LSP_NUM_LANES];
  lsp_emph_type lane_emph_out [`LSP_NUM_LANES];
  int miscompares = 0, compares = 0;
  int mdl [4] = '{0, 0, 0, 0};
  always #50 clk_in = ~clk_in;
  lsp_lane_regs dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wr_in(cfg_wr_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_hit_out(cfg_hit_out), .global_lane_control_reg_in(gctl),
    .glb_swing_in(glb_swing_in), .glb_emph_in(glb_emph_in), .lane_swing_out(lane_swing_out),
    .lane_emph_out(lane_emph_out));
  task automatic cmp_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_reg
  task automatic cmp_lane(input int i, input logic [4:0] exp);
    compares++;
    if ({lane_swing_out[i], lane_emph_out[i]} !== exp) begin
      miscompares++;
      $display("BAD lane%0d expected %h seen %h", i, exp, {lane_swing_out[i], lane_emph_out[i]});
    end
  endtask : cmp_lane
  // one config cycle; wr is left as set, the next call overwrites it
  task automatic access(input logic [7:0] a, input logic wr, input logic [7:0] d);
    logic hit;
    hit = (a >= 8'h31) && (a <= 8'h34);
    cfg_addr_in = a;
    cfg_wr_in = wr;
    cfg_wdata_in = d;
    #1 cmp_reg("hit", {7'h00, hit}, {7'h00, cfg_hit_out});
    @(posedge clk_in);
    #1;
    if (!wr) cmp_reg("rdata", hit ? 8'(mdl[a - 8'h31]) : 8'h00, cfg_rdata_out);
    if (wr && hit) mdl[a - 8'h31] = (a == 8'h31 && !gctl[7]) ? {d[7:5], 2'(mdl[0] >> 3), d[2:0]} : d;
  endtask : access
  task automatic check_lanes();
    logic en;
    logic [2:0] sw;
    logic [1:0] em;
    en = gctl[6] & gctl[5];
    for (int i = 0; i < 4; i++) begin
      sw = en ? 3'(mdl[i] >> 5) : glb_swing_in;
      em = en ? 2'(mdl[i] >> 3) : glb_emph_in;
      if (i == 0 && !gctl[7]) em = 2'h0;
      cmp_lane(i, {sw, em});
    end
  endtask : check_lanes
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  initial begin
    void'($urandom(32'h194b));
    repeat (5) @(posedge clk_in);
    #1 sys_rst_in = 1'b0;
    for (int a = 8'h30; a <= 8'h35; a++) access(8'(a), 1'b0, 8'h00);
    $display("test reset_values done");
    // code 11 is never written: software must keep off it
    for (int i = 0; i < 32; i++) begin
      gctl = 8'($urandom);
      glb_swing_in = 3'($urandom);
      glb_emph_in = 2'($urandom % 3);
      access(8'h31 + 8'(i % 4), 1'b1, {3'(i), 2'(i % 3), 3'($urandom)});
      access(8'h35, 1'b1, 8'($urandom));
      access(8'h31 + 8'(i % 4), 1'b0, 8'h00);
      access(8'h31, 1'b0, 8'h00);
      check_lanes();
    end
    $display("test random_access done");
    // a write held while the enable is low must leave register, read data and lanes untouched
    clk_en_in = 1'b0;
    cfg_addr_in = 8'h32;
    cfg_wr_in = 1'b1;
    cfg_wdata_in = ~8'(mdl[1]);
    repeat (3) @(posedge clk_in);
    #1;
    check_lanes();
    clk_en_in = 1'b1;
    cfg_wr_in = 1'b0;
    @(posedge clk_in);
    #1;
    cmp_reg("frozen", 8'(mdl[1]), cfg_rdata_out);
    check_lanes();
    $display("test clock_enable done");
    give_verdict();
  end
  // about 145 cycles expected; generous margin
  initial begin
    repeat (2000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end
endmodule : lane_swing_preemphasis_regs_tb_top
